// ==== inc/iex_pkg.sv ====
package iex_pkg;

  // register byte offsets on the slave bus
  localparam logic [3:0] IEX_OFS_VBASE = 4'h0;
  localparam logic [3:0] IEX_OFS_SWORD = 4'h4;
  localparam logic [3:0] IEX_OFS_STATE = 4'h8;
  localparam logic [3:0] IEX_OFS_LVEC  = 4'hc;

  // reset values
  localparam logic [31:0] IEX_RST_VBASE = 32'h0000_0000;
  localparam logic [15:0] IEX_RST_SWORD = 16'h2700;

  // status word field positions
  localparam int IEX_SW_TRACE_HIGH = 15;
  localparam int IEX_SW_TRACE_LOW  = 14;
  localparam int IEX_SW_SUPER      = 13;

  // trace control encodings
  localparam logic [1:0] IEX_TR_OFF  = 2'h0;
  localparam logic [1:0] IEX_TR_FLOW = 2'h1;
  localparam logic [1:0] IEX_TR_ALL  = 2'h2;

  // documented vector numbers
  localparam logic [7:0] IEX_VEC_PRIV   = 8'h08;
  localparam logic [7:0] IEX_VEC_ALINE  = 8'h0a;
  localparam logic [7:0] IEX_VEC_FLINE  = 8'h0b;
  localparam logic [7:0] IEX_VEC_HWBKPT = 8'h0c;
  localparam logic [7:0] IEX_VEC_FORMAT = 8'h0e;

  // opcodes and cpu space locations
  localparam logic [15:0] IEX_OP_RESERVED = 16'h4afc;
  localparam logic [15:0] IEX_OP_BKPT0    = 16'h4848;
  localparam logic [3:0]  IEX_LINE_A      = 4'ha;
  localparam logic [3:0]  IEX_LINE_F      = 4'hf;
  localparam logic [4:0]  IEX_CS_BKPT_ACK = 5'h1e;

  // execution outcome reported by the sequencer
  typedef enum logic [2:0] {
    IEX_CAUSE_NONE   = 3'b000,
    IEX_CAUSE_UNCOND = 3'b001,
    IEX_CAUSE_DIVZ   = 3'b010,
    IEX_CAUSE_BOUND  = 3'b011,
    IEX_CAUSE_COND   = 3'b100,
    IEX_CAUSE_FORMAT = 3'b101
  } iex_cause_t;

  typedef enum logic [2:0] {
    IEX_ST_IDLE = 3'b000,
    IEX_ST_BKRD = 3'b001,
    IEX_ST_EXEC = 3'b010,
    IEX_ST_EXC  = 3'b011,
    IEX_ST_ACK  = 3'b100
  } iex_state_t;

endpackage

// ==== core/iex_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module iex_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // pin side and clean side
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync
);

  logic [W-1:0] meta_ff;

  // two stages, the first read only by the second
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      meta_ff  <= '0;
      pin_sync <= '0;
    end
    else
    begin
      meta_ff  <= pin_in;
      pin_sync <= meta_ff;
    end
  end

endmodule
`default_nettype wire

// ==== core/iex_classify.sv ====
`timescale 1ns/1ps
`default_nettype none
module iex_classify
  import iex_pkg::*;
(
  // instruction words from the decoder
  input  wire logic [15:0] op_word,
  input  wire logic [15:0] ext_word,
  input  wire logic        ext_is_index,
  input  wire logic        ext_is_ctrl,
  input  wire logic        no_match,
  input  wire logic        user_mode,
  // classification
  output logic             cls_illegal,
  output logic             cls_aline,
  output logic             cls_fline,
  output logic             cls_priv,
  output logic             cls_bkpt
);

  logic lp_halt;
  logic ctrl_move;
  logic ctrl_bad;
  logic idx_bad;
  logic sup_only;

  // low power halt sits in the f-line space but is a real instruction
  assign lp_halt   = (op_word == 16'hf800) && (ext_word == 16'h01c0);
  assign ctrl_move = (op_word[15:1] == 15'h273d);
  // only four control registers exist
  assign ctrl_bad  = ctrl_move && ext_is_ctrl &&
                     (ext_word[11:0] != 12'h000) &&
                     (ext_word[11:0] != 12'h001) &&
                     (ext_word[11:0] != 12'h800) &&
                     (ext_word[11:0] != 12'h801);
  assign idx_bad   = ext_is_index &&
                     ((ext_word[5:4] == 2'h0) || (ext_word[3:0] != 4'h0));

  assign cls_aline   = (op_word[15:12] == IEX_LINE_A); // RULE15
  assign cls_fline   = (op_word[15:12] == IEX_LINE_F) && !lp_halt; // RULE16
  assign cls_illegal = no_match || ctrl_bad || idx_bad || // RULE14
                       (op_word == IEX_OP_RESERVED); // RULE17
  assign cls_bkpt    = (op_word[15:3] == IEX_OP_BKPT0[15:3]); // RULE7

  // supervisor-only opcodes
  assign sup_only = (op_word == 16'h027c) || (op_word == 16'h0a7c) ||
                    (op_word == 16'h007c) || lp_halt ||
                    (op_word[15:6] == 10'h103) ||
                    (op_word[15:6] == 10'h11b) ||
                    (op_word[15:4] == 12'h4e6) || ctrl_move ||
                    ((op_word[15:8] == 8'h0e) && (op_word[7:6] != 2'h3)) ||
                    (op_word == 16'h4e70) || (op_word == 16'h4e73) ||
                    (op_word == 16'h4e72);
  assign cls_priv = user_mode && sup_only; // RULE19

endmodule
`default_nettype wire

// ==== core/iex_recognizer.sv ====
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE1: unconditional trap always excepts, vector from opcode
// RULE2: conditional traps except only on error
// RULE3: divide by zero divisor excepts
// RULE4: trap exception first, trace exception after
// RULE5: trap frame holds vector, status, next pc
// RULE6: non-unconditional traps also stack instruction address
// RULE7: breakpoint opcodes read cpu space by number
// RULE8: fault means illegal; acknowledge substitutes word
// RULE9: hardware breakpoints held pending, tied ones later
// RULE10: acknowledge at boundaries, cpu space location 1e
// RULE11: normal end continues; fault starts exception
// RULE12: hardware breakpoint uses vector 12, six words
// RULE13: bad return frame uses vector 14
// RULE14: flag unmatched, bad control move, bad index
// RULE15: a-line words use vector 10
// RULE16: f-line words use vector 11
// RULE17: reserved opcode always illegal
// RULE18: illegal caught at decode, pc of instruction
// RULE19: user supervisor opcode gives vector 8
// RULE20: trace bits zero means no tracing
// RULE21: flow mode traces only changed flow
// RULE22: all mode traces completed instructions only
// RULE23: trace value 11 produces nothing
// RULE24: trace after instruction, frame with both pcs
// RULE25: vector address is base plus four times number
// RULE26: entry sets supervisor, clears trace bits
module iex_recognizer
  import iex_pkg::*;
#(
  parameter logic [7:0] VEC_ILLEGAL = 8'h04,
  parameter logic [7:0] VEC_DIVZ    = 8'h05,
  parameter logic [7:0] VEC_BOUND   = 8'h06,
  parameter logic [7:0] VEC_COND    = 8'h07,
  parameter logic [7:0] VEC_TRACE   = 8'h09,
  parameter logic [7:0] VEC_TRAP0   = 8'h20
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // decoder: instruction start
  input  wire logic        instr_valid,
  output logic             instr_ready,
  input  wire logic [15:0] op_word,
  input  wire logic [15:0] ext_word,
  input  wire logic        ext_is_index,
  input  wire logic        ext_is_ctrl,
  input  wire logic        no_match,
  input  wire logic [31:0] instr_pc,
  input  wire logic [31:0] next_pc,
  // sequencer: execution outcome
  input  wire logic        exec_done,
  input  wire logic [2:0]  exec_cause,
  input  wire logic        exec_flow,
  input  wire logic        sw_load,
  input  wire logic [15:0] sw_load_data,
  // sequencer: exception request
  output logic             exc_req,
  input  wire logic        exc_done,
  output logic [7:0]       exc_vector,
  output logic [31:0]      exc_vec_addr,
  output logic [31:0]      exc_stk_pc,
  output logic [31:0]      exc_stk_fpc,
  output logic             exc_six_word,
  output logic [15:0]      exc_stk_sw,
  output logic [15:0]      status_word,
  // cpu space read
  output logic             cs_rd_req,
  output logic [4:0]       cs_rd_addr,
  input  wire logic        cs_ack,
  input  wire logic        cs_fault,
  input  wire logic [15:0] cs_rdata,
  // breakpoint substitute word
  output logic             repl_valid,
  output logic [15:0]      repl_word,
  // hardware breakpoint pins
  input  wire logic        hw_bkpt_req,
  input  wire logic        hw_bkpt_instr
);

  iex_state_t  state_ff;
  iex_state_t  nxt_state;
  logic [31:0] vbase_ff;
  logic [15:0] sw_ff;
  logic [7:0]  last_vec_ff;
  logic [1:0]  trace_mode_ff;
  logic        trace_pend_ff;
  logic        bkpt_pend_ff;
  logic        bkpt_tag_ff;
  logic [31:0] cur_pc_ff;
  logic [31:0] nxt_pc_ff;
  logic        ack_ff;
  logic [1:0]  pin_sync;
  logic        cls_illegal;
  logic        cls_aline;
  logic        cls_fline;
  logic        cls_priv;
  logic        cls_bkpt;
  logic        instr_go;
  logic        lau_en;
  logic [7:0]  lau_vec;
  logic [31:0] lau_pc;
  logic [31:0] lau_fpc;
  logic        lau_six;
  logic        trace_hit;
  logic [1:0]  sw_trace;
  iex_cause_t  cause;

  // breakpoint pins come from outside the clock domain
  iex_sync #(
    .W (2)
  ) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pin_in   ({hw_bkpt_instr, hw_bkpt_req}),
    .pin_sync (pin_sync)
  );

  iex_classify u_class (
    .op_word      (op_word),
    .ext_word     (ext_word),
    .ext_is_index (ext_is_index),
    .ext_is_ctrl  (ext_is_ctrl),
    .no_match     (no_match),
    .user_mode    (!sw_ff[IEX_SW_SUPER]),
    .cls_illegal  (cls_illegal),
    .cls_aline    (cls_aline),
    .cls_fline    (cls_fline),
    .cls_priv     (cls_priv),
    .cls_bkpt     (cls_bkpt)
  );

  // new instructions wait while a breakpoint is pending
  assign instr_ready = (state_ff == IEX_ST_IDLE) && !bkpt_pend_ff; // RULE10
  assign instr_go    = instr_valid && instr_ready;
  assign sw_trace    = {sw_ff[IEX_SW_TRACE_HIGH], sw_ff[IEX_SW_TRACE_LOW]};
  assign cause       = iex_cause_t'(exec_cause);
  assign exc_req     = (state_ff == IEX_ST_EXC);
  assign cs_rd_req   = (state_ff == IEX_ST_BKRD) || (state_ff == IEX_ST_ACK);
  assign status_word = sw_ff;

  // trace decision from the mode latched at instruction start
  always_comb
  begin
    case (trace_mode_ff)
      IEX_TR_OFF:  trace_hit = 1'b0; // RULE20
      IEX_TR_FLOW: trace_hit = exec_flow; // RULE21
      IEX_TR_ALL:  trace_hit = 1'b1; // RULE22
      default:     trace_hit = 1'b0; // RULE23
    endcase
  end

  // exception launch and next state
  always_comb
  begin
    nxt_state = state_ff;
    lau_en    = 1'b0;
    lau_vec   = 8'h00;
    lau_pc    = instr_pc;
    lau_fpc   = cur_pc_ff;
    lau_six   = 1'b0;
    case (state_ff)
      IEX_ST_IDLE:
      begin
        if (bkpt_pend_ff)
          nxt_state = IEX_ST_ACK; // RULE10
        else if (instr_go)
        begin
          // decode-time exceptions: nothing executes, pc of this word
          lau_en    = cls_aline || cls_fline || cls_illegal || cls_priv;
          lau_pc    = instr_pc; // RULE18
          if (cls_aline)
            lau_vec = IEX_VEC_ALINE; // RULE15
          else if (cls_fline)
            lau_vec = IEX_VEC_FLINE; // RULE16
          else if (cls_illegal)
            lau_vec = VEC_ILLEGAL; // RULE14
          else
            lau_vec = IEX_VEC_PRIV; // RULE19
          if (lau_en)
            nxt_state = IEX_ST_EXC;
          else if (cls_bkpt)
            nxt_state = IEX_ST_BKRD; // RULE7
          else
            nxt_state = IEX_ST_EXEC;
        end
      end
      IEX_ST_BKRD:
      begin
        if (cs_fault)
        begin
          lau_en    = 1'b1; // RULE8
          lau_vec   = VEC_ILLEGAL;
          lau_pc    = cur_pc_ff;
          nxt_state = IEX_ST_EXC;
        end
        else if (cs_ack)
          nxt_state = IEX_ST_IDLE; // RULE8
      end
      IEX_ST_EXEC:
      begin
        if (exec_done)
        begin
          lau_pc  = nxt_pc_ff; // RULE5
          lau_six = 1'b1; // RULE6
          case (cause)
            IEX_CAUSE_UNCOND:
            begin
              lau_en  = 1'b1; // RULE1
              lau_six = 1'b0;
              lau_vec = VEC_TRAP0 + {4'h0, op_word[3:0]};
            end
            IEX_CAUSE_DIVZ:
            begin
              lau_en  = 1'b1; // RULE3
              lau_vec = VEC_DIVZ;
            end
            IEX_CAUSE_BOUND:
            begin
              lau_en  = 1'b1; // RULE2
              lau_vec = VEC_BOUND;
            end
            IEX_CAUSE_COND:
            begin
              lau_en  = 1'b1; // RULE2
              lau_vec = VEC_COND;
            end
            IEX_CAUSE_FORMAT:
            begin
              lau_en  = 1'b1; // RULE13
              lau_six = 1'b0;
              lau_pc  = cur_pc_ff;
              lau_vec = IEX_VEC_FORMAT;
            end
            default:
            begin
              // plain completion may still owe a trace
              lau_en  = trace_hit; // RULE24
              lau_vec = VEC_TRACE;
            end
          endcase
          nxt_state = lau_en ? IEX_ST_EXC : IEX_ST_IDLE;
        end
      end
      IEX_ST_EXC:
      begin
        if (exc_done)
        begin
          if (trace_pend_ff)
          begin
            // trap stacked first, its trace follows at once
            lau_en  = 1'b1; // RULE4
            lau_vec = VEC_TRACE;
            lau_pc  = nxt_pc_ff;
            lau_six = 1'b1;
          end
          else if (bkpt_pend_ff)
            nxt_state = IEX_ST_ACK; // RULE10
          else
            nxt_state = IEX_ST_IDLE;
        end
      end
      IEX_ST_ACK:
      begin
        if (cs_fault)
        begin
          lau_en    = 1'b1; // RULE11
          lau_vec   = IEX_VEC_HWBKPT; // RULE12
          lau_pc    = nxt_pc_ff;
          lau_six   = 1'b1;
          nxt_state = IEX_ST_EXC;
        end
        else if (cs_ack)
          nxt_state = IEX_ST_IDLE; // RULE11
      end
      default:
        nxt_state = IEX_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      state_ff <= IEX_ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // exception frame contents, held while the request stands
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      exc_vector   <= 8'h00;
      exc_vec_addr <= 32'h0000_0000;
      exc_stk_pc   <= 32'h0000_0000;
      exc_stk_fpc  <= 32'h0000_0000;
      exc_six_word <= 1'b0;
      exc_stk_sw   <= 16'h0000;
      last_vec_ff  <= 8'h00;
    end
    else if (lau_en)
    begin
      exc_vector   <= lau_vec;
      exc_vec_addr <= vbase_ff + {22'h00_0000, lau_vec, 2'h0}; // RULE25
      exc_stk_pc   <= lau_pc;
      exc_stk_fpc  <= lau_fpc; // RULE6
      exc_six_word <= lau_six;
      exc_stk_sw   <= sw_ff; // RULE5
      last_vec_ff  <= lau_vec;
    end
  end

  // instruction context latched at instruction start only
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cur_pc_ff     <= 32'h0000_0000;
      nxt_pc_ff     <= 32'h0000_0000;
      trace_mode_ff <= IEX_TR_OFF;
      bkpt_tag_ff   <= 1'b0;
    end
    else if (instr_go)
    begin
      cur_pc_ff     <= instr_pc;
      nxt_pc_ff     <= next_pc;
      trace_mode_ff <= sw_trace; // RULE4
      bkpt_tag_ff   <= pin_sync[1]; // RULE9
    end
  end

  // trace owed after the trap frame; decode exceptions never owe one
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      trace_pend_ff <= 1'b0;
    else if (state_ff == IEX_ST_EXEC && exec_done && lau_en &&
             cause != IEX_CAUSE_NONE)
      trace_pend_ff <= trace_hit && (cause != IEX_CAUSE_FORMAT); // RULE4
    else if (state_ff == IEX_ST_EXC && exc_done)
      trace_pend_ff <= 1'b0;
  end

  // pending breakpoint: a new request beats the acknowledge clear
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      bkpt_pend_ff <= 1'b0;
    else if (pin_sync[0] || (state_ff == IEX_ST_EXEC && exec_done &&
             bkpt_tag_ff))
      bkpt_pend_ff <= 1'b1; // RULE9
    else if (state_ff == IEX_ST_ACK && (cs_ack || cs_fault))
      bkpt_pend_ff <= 1'b0; // RULE11
  end

  // cpu space address; acknowledge data is dropped
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cs_rd_addr <= 5'h00;
    else if (nxt_state == IEX_ST_ACK)
      cs_rd_addr <= IEX_CS_BKPT_ACK; // RULE10
    else if (instr_go)
      cs_rd_addr <= {op_word[2:0], 2'h0}; // RULE7
  end

  // breakpoint answer replaces the opcode in the pipe
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      repl_valid <= 1'b0;
      repl_word  <= 16'h0000;
    end
    else
    begin
      repl_valid <= (state_ff == IEX_ST_BKRD) && cs_ack && !cs_fault;
      if (state_ff == IEX_ST_BKRD && cs_ack)
        repl_word <= cs_rdata; // RULE8
    end
  end

  // status word: entry forces supervisor and stops tracing
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      sw_ff <= IEX_RST_SWORD;
    else if (lau_en)
    begin
      sw_ff[IEX_SW_SUPER]      <= 1'b1; // RULE26
      sw_ff[IEX_SW_TRACE_HIGH] <= 1'b0; // RULE26
      sw_ff[IEX_SW_TRACE_LOW]  <= 1'b0; // RULE26
    end
    else if (sw_load)
      sw_ff <= sw_load_data;
    else if (avs_write && ack_ff && avs_address == IEX_OFS_SWORD)
    begin
      if (avs_byteenable[0])
        sw_ff[7:0] <= avs_writedata[7:0];
      if (avs_byteenable[1])
        sw_ff[15:8] <= avs_writedata[15:8];
    end
  end

  // vector base: per-lane writes
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      vbase_ff <= IEX_RST_VBASE;
    else if (avs_write && ack_ff && avs_address == IEX_OFS_VBASE)
    begin
      for (int i = 0; i < 4; i++)
        if (avs_byteenable[i])
          vbase_ff[8*i +: 8] <= avs_writedata[8*i +: 8];
    end
  end

  // one wait state per access so read data is registered
  assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ack_ff       <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      ack_ff <= (avs_read || avs_write) && !ack_ff;
      case (avs_address)
        IEX_OFS_VBASE: avs_readdata <= vbase_ff;
        IEX_OFS_SWORD: avs_readdata <= {16'h0000, sw_ff};
        IEX_OFS_STATE: avs_readdata <= {24'h00_0000, trace_mode_ff,
                                        trace_pend_ff, bkpt_pend_ff,
                                        exc_req, state_ff};
        IEX_OFS_LVEC:  avs_readdata <= {24'h00_0000, last_vec_ff};
        default:       avs_readdata <= 32'h0000_0000; // unmapped
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== test/iex_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module iex_properties
  import iex_pkg::*;
#(
  parameter logic [7:0] VEC_ILLEGAL = 8'h04
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // decoder side
  input wire logic        instr_valid,
  input wire logic        instr_ready,
  input wire logic [15:0] op_word,
  input wire logic [31:0] instr_pc,
  // exception request
  input wire logic        exc_req,
  input wire logic [7:0]  exc_vector,
  input wire logic [31:0] exc_stk_pc,
  input wire logic [15:0] status_word,
  // cpu space read and substitute
  input wire logic        cs_rd_req,
  input wire logic [4:0]  cs_rd_addr,
  input wire logic        cs_ack,
  input wire logic        cs_fault,
  input wire logic [15:0] cs_rdata,
  input wire logic        repl_valid,
  input wire logic [15:0] repl_word
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // accepted instruction and its breakpoint number
  wire logic take;
  wire logic ack_rd;
  logic [2:0] bnum_ff;
  assign take = instr_valid && instr_ready;
  assign ack_rd = cs_rd_req && cs_rd_addr == IEX_CS_BKPT_ACK;
  always_ff @(posedge clk)
    bnum_ff <= op_word[2:0];

  property p_aline;
    take && op_word[15:12] == IEX_LINE_A |=> exc_req &&
      exc_vector == IEX_VEC_ALINE && exc_stk_pc == $past(instr_pc);
  endproperty
  a_aline: assert property (p_aline) else $error("a-line entry wrong");
  property p_fline;
    take && op_word[15:12] == IEX_LINE_F && op_word != 16'hf800
      |=> exc_req && exc_vector == IEX_VEC_FLINE;
  endproperty
  a_fline: assert property (p_fline) else $error("f-line entry wrong");
  property p_resv;
    take && op_word == IEX_OP_RESERVED |=> exc_req && exc_vector == VEC_ILLEGAL;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved op missed");
  property p_priv;
    take && !status_word[IEX_SW_SUPER] && op_word == 16'h4e73
      |=> exc_req && exc_vector == IEX_VEC_PRIV;
  endproperty
  a_priv: assert property (p_priv) else $error("privilege missed");
  property p_entry;
    exc_req |-> status_word[IEX_SW_SUPER] && status_word[15:14] == 2'h0;
  endproperty
  a_entry: assert property (p_entry) else $error("entry status wrong");
  property p_bkpt;
    take && op_word[15:3] == IEX_OP_BKPT0[15:3]
      |=> cs_rd_req && cs_rd_addr == {bnum_ff, 2'h0};
  endproperty
  a_bkpt: assert property (p_bkpt) else $error("breakpoint read wrong");
  property p_repl;
    cs_rd_req && !ack_rd && cs_ack && !cs_fault
      |=> repl_valid && repl_word == $past(cs_rdata);
  endproperty
  a_repl: assert property (p_repl) else $error("substitute word wrong");
  property p_bfault;
    cs_rd_req && !ack_rd && cs_fault
      |-> ##[1:2] (exc_req && exc_vector == VEC_ILLEGAL);
  endproperty
  a_bfault: assert property (p_bfault) else $error("fault not illegal");
  property p_hwf;
    ack_rd && cs_fault |-> ##[1:2] (exc_req && exc_vector == IEX_VEC_HWBKPT);
  endproperty
  a_hwf: assert property (p_hwf) else $error("hw breakpoint vector wrong");

  // main scenarios reached
  c_aline: cover property (take && op_word[15:12] == IEX_LINE_A);
  c_fault: cover property (cs_rd_req && cs_fault);
  c_repl: cover property (repl_valid);
endmodule

bind iex_recognizer iex_properties #(.VEC_ILLEGAL(VEC_ILLEGAL)) u_props (.*);
`default_nettype wire

// ==== test/iex_cs_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module iex_cs_partner (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // cpu space bus
  input  wire logic        cs_rd_req,
  output logic             cs_ack,
  output logic             cs_fault,
  output logic      [15:0] cs_rdata,
  // bench controls
  input  wire logic        flt,
  input  wire logic [7:0]  dly,
  input  wire logic [15:0] bdata
);
  logic [7:0] cnt_ff;

  // answer after dly cycles; data toggles outside the answer pulse
  always_ff @(posedge clk)
  begin
    cs_ack <= 1'b0;
    cs_fault <= 1'b0;
    cs_rdata <= sys_rst ? 16'h5a5a : ~cs_rdata;
    cnt_ff <= 8'h00;
    if (!sys_rst && cs_rd_req && !cs_ack && !cs_fault)
    begin
      cnt_ff <= cnt_ff + 8'h01;
      if (cnt_ff == dly)
      begin
        cs_ack <= !flt;
        cs_fault <= flt;
        cs_rdata <= bdata;
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/iex_recognizer_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CMP(n, e, s) begin checked++; if ((s) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module iex_recognizer_test;
  import iex_pkg::*;
  logic clk, sys_rst, avs_read, avs_write, avs_waitrequest, instr_valid;
  logic instr_ready, ext_is_index, ext_is_ctrl, no_match, exec_done;
  logic exec_flow, sw_load, exc_req, exc_done, exc_six_word, cs_rd_req;
  logic cs_ack, cs_fault, repl_valid, hw_bkpt_req, hw_bkpt_instr, flt;
  logic [2:0] exec_cause;
  logic [3:0] avs_address, avs_byteenable;
  logic [4:0] cs_rd_addr;
  logic [7:0] exc_vector, dly;
  logic [15:0] op_word, ext_word, sw_load_data, exc_stk_sw, status_word;
  logic [15:0] cs_rdata, repl_word, bdata;
  logic [31:0] avs_writedata, avs_readdata, instr_pc, next_pc, rd;
  logic [31:0] exc_vec_addr, exc_stk_pc, exc_stk_fpc;
  int failures, checked, vbase, sw, pc, n, f, q[$];
  int cv[6] = '{0, 32, 5, 6, 7, 14};
  int dv[6] = '{10, 11, 4, 4, 4, 4};
  logic [15:0] ops[6] = '{16'ha123, 16'hf123, 16'h4afc, 16'h4e71, 16'h4e71,
                          16'h4e7a};

  iex_recognizer uut (.*);
  iex_cs_partner u_far (.*);

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic close_out;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // bounded wait for a level, sampled mid-cycle
  task automatic hold(ref logic s, input logic lvl);
    int k;
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
      if (k > 80)
      begin
        failures++;
        close_out();
      end
    end
    while (s !== lvl);
  endtask

  // avalon master: held until waitrequest seen low at an edge
  task automatic av(input bit w, input logic [3:0] a, input int d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    hold(avs_waitrequest, 1'b0);
    @(posedge clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic setsw(input int v);
    av(1, IEX_OFS_SWORD, v);
    sw = v;
  endtask

  task automatic exp(input int v, p, fp, s);
    q = {q, v, p, fp, s};
  endtask

  // offer one instruction; executed ones end with a done pulse
  task automatic ins(input int op, c, fl, dec);
    op_word <= op;
    instr_pc <= pc;
    next_pc <= pc + 2;
    instr_valid <= 1'b1;
    hold(instr_ready, 1'b1);
    @(posedge clk);
    instr_valid <= 1'b0;
    if (!dec)
    begin
      exec_cause <= c;
      exec_flow <= fl;
      exec_done <= 1'b1;
      @(posedge clk);
      exec_done <= 1'b0;
    end
  endtask

  // take every expected frame in order, then expect silence
  task automatic serve;
    int v, p, fp, s;
    while (q.size() > 0)
    begin
      v = q.pop_front();
      p = q.pop_front();
      fp = q.pop_front();
      s = q.pop_front();
      hold(exc_req, 1'b1);
      `CMP("vector", v, exc_vector)
      `CMP("vaddr", vbase + 4 * v, exc_vec_addr)
      `CMP("pc", p, exc_stk_pc)
      `CMP("six", s[0], exc_six_word)
      if (s != 0) `CMP("fpc", fp, exc_stk_fpc)
      `CMP("old sw", sw[15:0], exc_stk_sw)
      sw = (sw | 'h2000) & 'h3fff;
      `CMP("sw", sw[15:0], status_word)
      @(posedge clk);
      exc_done <= 1'b1;
      @(posedge clk);
      exc_done <= 1'b0;
    end
    @(negedge clk);
    `CMP("quiet", 1'b0, exc_req)
    @(posedge clk);
    pc += 2;
  endtask

  initial
  begin
    {avs_read, avs_write, instr_valid, ext_is_index, ext_is_ctrl} = '0;
    {no_match, exec_done, exec_flow, sw_load, exc_done, flt} = '0;
    {hw_bkpt_req, hw_bkpt_instr, exec_cause, op_word, sw_load_data} = '0;
    {avs_address, avs_writedata, instr_pc, next_pc, dly, bdata} = '0;
    avs_byteenable = 4'hf;
    ext_word = 16'h0002;
    sys_rst = 1'b1;
    {failures, checked} = '0;
    void'($urandom(29015));
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    // reset values, unmapped place, vector base
    av(0, IEX_OFS_SWORD, 0);
    `CMP("sw reset", 'h2700, rd)
    av(0, 4'h1, 0);
    `CMP("unmapped", 0, rd)
    vbase = $urandom;
    av(1, IEX_OFS_VBASE, vbase);
    av(0, IEX_OFS_VBASE, 0);
    `CMP("vbase", vbase, rd)
    sw = 'h2700;
    pc = $urandom & 'hfff0;
    // decode-time exceptions while tracing every instruction
    for (int i = 0; i < 6; i++)
    begin
      setsw('ha700);
      ext_is_index <= (i == 3);
      no_match <= (i == 4);
      ext_is_ctrl <= (i == 5);
      exp(dv[i], pc, pc, 0);
      ins(ops[i], 0, 0, 1);
      serve();
    end
    {ext_is_index, no_match, ext_is_ctrl} <= '0;
    // user state supervisor opcode
    sw_load_data <= 16'h0000;
    sw_load <= 1'b1;
    @(posedge clk);
    sw_load <= 1'b0;
    sw = 0;
    exp(8, pc, pc, 0);
    ins('h4e73, 0, 0, 1);
    serve();
    // every trace mode against every execution outcome
    for (int t = 0; t < 4; t++)
      for (int c = 0; c < 6; c++)
      begin
        n = $urandom % 16;
        f = $urandom % 2;
        setsw(t * 'h4000 + 'h2700);
        if (c > 0)
          exp(c == 1 ? 32 + n : cv[c], c == 5 ? pc : pc + 2, pc,
              c > 1 && c < 5);
        if ((t == 2 || (t == 1 && f != 0)) && c != 5)
          exp(9, pc + 2, pc, 1);
        ins(c == 1 ? 'h4e40 + n : 'h4e71, c, f, 0);
        serve();
      end
    // software breakpoints, fault on odd numbers
    for (int k = 0; k < 8; k++)
    begin
      flt <= k[0];
      dly <= $urandom % 4;
      bdata <= $urandom;
      if (k[0]) exp(4, pc, pc, 0);
      ins('h4848 + k, 0, 0, 1);
      if (!k[0])
      begin
        hold(repl_valid, 1'b1);
        `CMP("repl", bdata, repl_word)
        @(posedge clk);
      end
      serve();
    end
    // pin breakpoint faulted, then normal, then tied to an instruction
    for (int k = 0; k < 3; k++)
    begin
      flt <= (k != 1);
      if (k != 1) exp(12, pc + k, pc + k - 2, 1);
      hw_bkpt_req <= (k < 2);
      hw_bkpt_instr <= (k == 2);
      repeat (2) @(posedge clk);
      hw_bkpt_req <= 1'b0;
      if (k == 2) ins('h4e71, 0, 0, 0);
      repeat (12) @(posedge clk);
      serve();
    end
    close_out();
  end
endmodule
`default_nettype wire
